// ---- rtl/drive_msg_pkg.sv ----
package drive_msg_pkg;
  localparam int          MSG_BYTES      = 8;
  localparam logic [3:0]  MSG_TYPE_1     = 4'h1;
  localparam logic [3:0]  MSG_TYPE_2     = 4'h2;
  localparam logic [3:0]  AXIS_ZERO      = 4'h0;
  localparam logic [7:0]  BYTE_ZERO      = 8'h00;
  // type 2 opcodes
  localparam logic [7:0]  OP2_PARAM_RD   = 8'h84;
  localparam logic [7:0]  OP2_POS_RD     = 8'h88;
  localparam logic [7:0]  OP2_RD_89      = 8'h89;
  localparam logic [7:0]  OP2_WR32       = 8'h9E;
  localparam logic [7:0]  OP2_REG_RD32   = 8'h9F;
  // type 1 opcodes
  localparam logic [15:0] OP1_MOVE_DIST  = 16'h00B6;
  localparam logic [15:0] OP1_FEED_SENS  = 16'h006B;
  localparam logic [15:0] OP1_VEL_SET    = 16'h001D;
  // io encoding
  localparam logic [7:0]  EDGE_RISING    = 8'h52;
  localparam logic [7:0]  INPUT_TWO      = 8'hB2;
  // status code bit positions and reset values
  localparam int          STAT_FAULT_BIT = 0;
  localparam int          STAT_MOTION_BIT = 4;
  localparam logic [15:0] STATUS_RST     = 16'h0000;
  localparam logic [31:0] DIST_RST       = 32'h0000_0000;
  localparam logic [15:0] VEL_RST        = 16'h0000;

  typedef logic [MSG_BYTES*8-1:0] msg_t;

  // byte n of a message, byte 0 in the top bits
  function automatic logic [7:0] msgByte(input msg_t m, input int n);
    msgByte = m[(MSG_BYTES-1-n)*8 +: 8];
  endfunction
endpackage

// ---- rtl/drive_msg_if.sv ----
`timescale 1ns/1ps
interface drive_msg_if;
  import drive_msg_pkg::*;
  logic cmdValid;
  logic cmdReady;
  msg_t cmdMsg;
  logic rspValid;
  logic rspReady;
  msg_t rspMsg;
  modport host (output cmdValid, output cmdMsg, input cmdReady,
                input rspValid, input rspMsg, output rspReady);
  modport drive (input cmdValid, input cmdMsg, output cmdReady,
                 output rspValid, output rspMsg, input rspReady);
endinterface

// ---- rtl/drive_msg_device.sv ----
// How it works
// - only type 2 returns read data
// - type 2: opcode byte 2, operand byte 3
// - host: type 2 byte1 axis0/type2, byte0 zero
// - type 2 data bytes 4-5; 0x9E 32-bit
// - type 2 response echoes opcode and operand
// - type 2 response byte1 axis0/type2, byte0 zero
// - status code in bytes 4-5 by default
// - status bits flag fault and motion
// - response width 16 or 32 by opcode
// - 0x84/0x88/0x89 read data in bytes 4-5
// - 0x9F returns 32 bits in bytes 4-7
// - bytes 6-7 zero except 0x9F
// - move distance takes 32-bit step count
// - feed to sensor stops distance after edge
// - feed operand: edge byte 6, input byte 7
// - velocity in quarter-rpm units
`timescale 1ns/1ps
module drive_msg_device
  import drive_msg_pkg::*;
(
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        clkEn,
  // message link
  drive_msg_if.drive       link,
  // drive state
  input  wire logic        faultIn,
  input  wire logic        sensorIn2,
  input  wire logic [15:0] paramRdData,
  input  wire logic [31:0] wideRdData,
  // drive control
  output logic             motorRun,
  output logic [31:0]      moveDist,
  output logic [15:0]      velocity,
  output logic             t2WrStb,
  output logic [7:0]       t2WrOpcode,
  output logic [7:0]       t2WrOperand,
  output logic [31:0]      t2WrData
);
  logic        busy_r;
  logic        ready_r;
  msg_t        rsp_r;
  logic        motorRun_r;
  logic [31:0] moveDist_r;
  logic [31:0] stepsLeft_r;
  logic        armed_r;
  logic [15:0] velocity_r;
  logic        wrStb_r;
  logic [7:0]  wrOp_r;
  logic [7:0]  wrOpd_r;
  logic [31:0] wrData_r;
  logic [2:0]  sensSync_r;
  logic        sensLvl_r;

  wire  [7:0]  b1     = msgByte(link.cmdMsg, 1);
  wire  [7:0]  b2     = msgByte(link.cmdMsg, 2);
  wire  [7:0]  b3     = msgByte(link.cmdMsg, 3);
  wire  [7:0]  b4     = msgByte(link.cmdMsg, 4);
  wire  [7:0]  b5     = msgByte(link.cmdMsg, 5);
  wire  [7:0]  b6     = msgByte(link.cmdMsg, 6);
  wire  [7:0]  b7     = msgByte(link.cmdMsg, 7);
  wire         isT2   = (b1[3:0] == MSG_TYPE_2);
  wire  [15:0] op1    = {BYTE_ZERO, b3};
  wire         take   = link.cmdValid & ~busy_r;
  wire         done   = link.rspReady & busy_r;
  wire  [15:0] status;
  wire         rd16   = (b2 == OP2_PARAM_RD) | (b2 == OP2_POS_RD) | (b2 == OP2_RD_89);
  wire         rd32   = (b2 == OP2_REG_RD32);
  wire  [31:0] dat32  = {b4, b5, b6, b7};
  wire  [15:0] word45 = rd16 ? paramRdData : status;
  wire  [15:0] word67 = rd32 ? wideRdData[15:0] : 16'h0000;
  wire         t1Take = take & ~isT2;
  wire         t2Wr   = take & isT2 & ~rd16 & ~rd32;
  wire         feedGo = t1Take & (op1 == OP1_FEED_SENS)
                        & (b6 == EDGE_RISING) & (b7 == INPUT_TWO);
  wire         lastStep = stepsLeft_r <= 32'h0000_0001;
  msg_t        rspT2;
  msg_t        rspT1;
  wire         sensRise = sensLvl_r == 1'b0 && sensSync_r[1] && sensSync_r[2];
  wire         sensFall = sensLvl_r == 1'b1 && !sensSync_r[1] && !sensSync_r[2];
  wire         armNow   = motorRun_r & ~armed_r & sensRise;

  // status bits; other positions reserved here
  assign status = STATUS_RST | (16'(faultIn) << STAT_FAULT_BIT)
                  | (16'(motorRun_r) << STAT_MOTION_BIT);
  assign rspT2  = {BYTE_ZERO, AXIS_ZERO, MSG_TYPE_2, b2, b3,
                   (rd32 ? wideRdData[31:16] : word45), word67};
  // type 1 never carries read data back
  assign rspT1  = {BYTE_ZERO, b1, BYTE_ZERO, b3, status, 16'h0000};

  // ready is a flop of its own, so the link never sees a gate after busy
  assign link.cmdReady = ready_r;
  assign link.rspValid = busy_r;
  assign link.rspMsg   = rsp_r;
  assign motorRun      = motorRun_r;
  assign moveDist      = moveDist_r;
  assign velocity      = velocity_r;
  assign t2WrStb       = wrStb_r;
  assign t2WrOpcode    = wrOp_r;
  assign t2WrOperand   = wrOpd_r;
  assign t2WrData      = wrData_r;

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      busy_r <= 1'b0;
      rsp_r  <= '0;
      ready_r <= 1'b1;
    end
    else if (clkEn)
    begin
      if (take)
      begin
        busy_r <= 1'b1;
        ready_r <= 1'b0;
        rsp_r  <= isT2 ? rspT2 : rspT1;
      end
      else if (done)
      begin
        busy_r  <= 1'b0;
        ready_r <= 1'b1;
      end
    end
  end

  // pin synchroniser: change counts once stages 2 and 3 agree
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      // resets to the idle pin level, so no false edge follows reset
      sensSync_r <= 3'b000;
      sensLvl_r  <= 1'b0;
    end
    else if (clkEn)
    begin
      sensSync_r <= {sensSync_r[1:0], sensorIn2};
      if (sensRise)
        sensLvl_r <= 1'b1;
      else if (sensFall)
        sensLvl_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      moveDist_r  <= DIST_RST;
      velocity_r  <= VEL_RST;
      motorRun_r  <= 1'b0;
      armed_r     <= 1'b0;
      stepsLeft_r <= DIST_RST;
      wrStb_r     <= 1'b0;
      wrOp_r      <= BYTE_ZERO;
      wrOpd_r     <= BYTE_ZERO;
      wrData_r    <= 32'h0000_0000;
    end
    else if (clkEn)
    begin
      wrStb_r <= 1'b0;
      if (t2Wr)
      begin
        wrStb_r  <= 1'b1;
        wrOp_r   <= b2;
        wrOpd_r  <= b3;
        // 0x9E spans four bytes, all others two
        wrData_r <= (b2 == OP2_WR32) ? dat32 : {16'h0000, b4, b5};
      end
      if (t1Take && op1 == OP1_MOVE_DIST)
        moveDist_r <= dat32;
      if (t1Take && op1 == OP1_VEL_SET)
        velocity_r <= {b6, b7};
      // a fresh feed rearms; an edge seen before it is ignored
      if (feedGo)
      begin
        motorRun_r <= 1'b1;
        armed_r    <= 1'b0;
      end
      // distance latched at the edge, so a later distance command cannot cut this move
      else if (armNow)
      begin
        armed_r     <= 1'b1;
        stepsLeft_r <= moveDist_r;
        if (moveDist_r == 32'h0000_0000)
          motorRun_r <= 1'b0;
      end
      else if (motorRun_r && armed_r)
      begin
        // one step per enabled cycle; a stand-in for the step generator
        stepsLeft_r <= stepsLeft_r - 32'h0000_0001;
        if (lastStep)
        begin
          motorRun_r <= 1'b0;
          armed_r    <= 1'b0;
        end
      end
    end
  end
endmodule

// ---- rtl/drive_msg_host.sv ----
`timescale 1ns/1ps
module drive_msg_host
  import drive_msg_pkg::*;
(
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        clkEn,
  // user request
  input  wire logic        reqValid,
  output logic             reqReady,
  input  wire logic        reqType2,
  input  wire logic [15:0] reqOpcode,
  input  wire logic [7:0]  reqOperand,
  input  wire logic [31:0] reqData,
  // user answer
  output logic             ansValid,
  output logic [7:0]       ansOpcode,
  output logic [7:0]       ansOperand,
  output logic [31:0]      ansData,
  // message link
  drive_msg_if.host        link
);
  logic        wait_r;
  logic        ready_r;
  logic        rspRdy_r;
  logic        cmdValid_r;
  msg_t        cmd_r;
  logic        ansValid_r;
  logic [7:0]  ansOp_r;
  logic [7:0]  ansOpd_r;
  logic [31:0] ansData_r;

  wire  [7:0]  opLo  = reqOpcode[7:0];
  wire         wide  = opLo == OP2_WR32;
  msg_t        cmdT2;
  msg_t        cmdT1;
  // byte 0 zero, axis zero
  assign cmdT2 = {BYTE_ZERO, AXIS_ZERO, MSG_TYPE_2, opLo, reqOperand,
                  (wide ? reqData : {reqData[15:0], 16'h0000})};
  // type 1 carries its operand in the low bytes, e.g. edge in 6 and input in 7
  assign cmdT1 = {BYTE_ZERO, AXIS_ZERO, MSG_TYPE_1, BYTE_ZERO, opLo,
                  reqData};
  wire         go    = reqValid & ~wait_r;

  assign reqReady      = ready_r;
  assign ansValid      = ansValid_r;
  assign ansOpcode     = ansOp_r;
  assign ansOperand    = ansOpd_r;
  assign ansData       = ansData_r;
  assign link.cmdValid = cmdValid_r;
  assign link.cmdMsg   = cmd_r;
  assign link.rspReady = rspRdy_r;

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      wait_r     <= 1'b0;
      ready_r    <= 1'b1;
      rspRdy_r   <= 1'b0;
      cmdValid_r <= 1'b0;
      cmd_r      <= '0;
      ansValid_r <= 1'b0;
      ansOp_r    <= BYTE_ZERO;
      ansOpd_r   <= BYTE_ZERO;
      ansData_r  <= 32'h0000_0000;
    end
    else if (clkEn)
    begin
      ansValid_r <= 1'b0;
      if (go)
      begin
        wait_r     <= 1'b1;
        ready_r    <= 1'b0;
        cmdValid_r <= 1'b1;
        cmd_r      <= reqType2 ? cmdT2 : cmdT1;
      end
      else if (cmdValid_r && link.cmdReady)
      begin
        cmdValid_r <= 1'b0;
        rspRdy_r   <= 1'b1;
      end
      // one outstanding command keeps answers in order
      else if (wait_r && link.rspValid)
      begin
        wait_r     <= 1'b0;
        ready_r    <= 1'b1;
        rspRdy_r   <= 1'b0;
        ansValid_r <= 1'b1;
        ansOp_r    <= msgByte(link.rspMsg, 2);
        ansOpd_r   <= msgByte(link.rspMsg, 3);
        ansData_r  <= link.rspMsg[31:0];
      end
    end
  end
endmodule

// ---- sim/drive_msg_monitor.sv ----
`timescale 1ns/1ps
module drive_msg_monitor
  import drive_msg_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // message link
  input wire logic cmdValid,
  input wire logic cmdReady,
  input wire msg_t cmdMsg,
  input wire logic rspValid,
  input wire logic rspReady,
  input wire msg_t rspMsg
);
  msg_t       cmdR;
  wire  logic take = cmdValid && cmdReady;
  wire  logic isT2 = cmdR[55:48] == 8'h02;
  wire  logic wide = isT2 && cmdR[47:40] == OP2_REG_RD32;
  // last taken command, so each response can be tied to its cause
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      cmdR <= '0;
    else if (take)
      cmdR <= cmdMsg;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_rsp_follows: assert property (take |=> rspValid)
    else $error("no response after command");
  a_rsp_holds: assert property (rspValid && !rspReady |=> rspValid && $stable(rspMsg))
    else $error("response dropped or changed");
  a_rsp_single: assert property (rspValid && rspReady |=> !rspValid)
    else $error("response repeated");
  a_busy_refuse: assert property (rspValid |-> !cmdReady)
    else $error("command accepted while response pending");
  a_t2_header: assert property (rspValid && isT2 |-> rspMsg[63:32] == {16'h0002, cmdR[47:32]})
    else $error("type 2 response header wrong");
  a_t1_echo: assert property (rspValid && cmdR[55:48] == 8'h01 |-> rspMsg[63:32] == {24'h000100, cmdR[39:32]})
    else $error("type 1 response header wrong");
  a_tail_zero: assert property (rspValid && !wide |-> rspMsg[15:0] == 16'h0000)
    else $error("response tail not zero");
  a_t2_frame: assert property (cmdValid && cmdMsg[55:48] == 8'h02 && cmdMsg[47:40] != OP2_WR32 |->
    cmdMsg[63:56] == 8'h00 && cmdMsg[15:0] == 16'h0000) else $error("type 2 command frame wrong");
  a_t1_frame: assert property (cmdValid && cmdMsg[55:48] == 8'h01 |-> cmdMsg[63:40] == 24'h000100)
    else $error("type 1 command frame wrong");
  c_t1: cover property (take && cmdMsg[55:48] == 8'h01);
  c_wide: cover property (rspValid && wide);
  c_t2_done: cover property (rspValid && rspReady && isT2);
endmodule

// ---- sim/tb_drive_msg_codec.sv ----
`timescale 1ns/1ps
module tb_drive_msg_codec
  import drive_msg_pkg::*;
;
  logic        clk_sys = 0, rst = 1, clkEn = 1, reqValid = 0, reqType2 = 0, faultIn = 0, sensorIn2 = 0;
  logic [15:0] reqOpcode = 16'h0000, paramRdData = 16'h0000, velocity;
  logic [7:0]  reqOperand = 8'h00, ansOpcode, ansOperand, t2WrOpcode, t2WrOperand;
  logic [31:0] reqData = 32'h0, wideRdData = 32'h0, ansData, moveDist, t2WrData, d;
  logic        reqReady, ansValid, motorRun, t2WrStb;
  logic [7:0]  ops [6] = '{8'h84, 8'h88, 8'h89, 8'h9F, 8'h83, 8'h9E};
  int          failures = 0, total_checks = 0, cyc = 0, seed = 74897, stbCnt = 0, n;
  always #25 clk_sys = ~clk_sys;
  drive_msg_if link();
  drive_msg_host u_drive_msg_host (.clk_sys(clk_sys), .rst(rst), .clkEn(clkEn), .reqValid(reqValid),
    .reqReady(reqReady), .reqType2(reqType2), .reqOpcode(reqOpcode), .reqOperand(reqOperand), .reqData(reqData),
    .ansValid(ansValid), .ansOpcode(ansOpcode), .ansOperand(ansOperand), .ansData(ansData), .link(link));
  drive_msg_device u_drive_msg_device (.clk_sys(clk_sys), .rst(rst), .clkEn(clkEn), .link(link),
    .faultIn(faultIn), .sensorIn2(sensorIn2), .paramRdData(paramRdData), .wideRdData(wideRdData),
    .motorRun(motorRun), .moveDist(moveDist), .velocity(velocity), .t2WrStb(t2WrStb),
    .t2WrOpcode(t2WrOpcode), .t2WrOperand(t2WrOperand), .t2WrData(t2WrData));
  drive_msg_monitor u_drive_msg_monitor (.clk_sys(clk_sys), .rst(rst), .cmdValid(link.cmdValid),
    .cmdReady(link.cmdReady), .cmdMsg(link.cmdMsg), .rspValid(link.rspValid), .rspReady(link.rspReady),
    .rspMsg(link.rspMsg));
  always @(posedge clk_sys)
  begin
    if (t2WrStb === 1'b1) stbCnt++;
    cyc++;
    if (cyc == 4000)
    begin
      failures++;
      test_done();
    end
  end
  function automatic logic isRead(input logic [7:0] op);
    return op == OP2_PARAM_RD || op == OP2_POS_RD || op == OP2_RD_89 || op == OP2_REG_RD32;
  endfunction
  // status is sampled at take, so inputs must not move while a request is in flight
  function automatic logic [31:0] expData(input logic t2, input logic [7:0] op);
    if (t2 && op == OP2_REG_RD32) return wideRdData;
    if (t2 && isRead(op)) return {paramRdData, 16'h0000};
    return {11'h000, motorRun, 3'h0, faultIn, 16'h0000};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    total_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("MISMATCH %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic doReq(input logic t2, input logic [15:0] op, input logic [7:0] opd, input logic [31:0] dat);
    logic [31:0] ed;
    int          s0;
    ed = expData(t2, op[7:0]);
    s0 = stbCnt;
    reqValid = 1;
    reqType2 = t2;
    reqOpcode = op;
    reqOperand = opd;
    reqData = dat;
    @(posedge clk_sys);
    #5 reqValid = 0;
    n = 0;
    while (ansValid !== 1'b1 && n < 20)
    begin
      @(posedge clk_sys);
      #5 n++;
    end
    check(32'(n < 20), 32'h0000_0001, "answer timeout");
    check({31'h0, reqReady}, 32'h0000_0001, "ready after answer");
    check({16'h0000, ansOpcode, ansOperand}, t2 ? {16'h0000, op[7:0], opd} : {24'h0, op[7:0]}, "echo");
    check(ansData, ed, "answer data");
    check(32'(stbCnt - s0), 32'(t2 && !isRead(op[7:0])), "write strobe count");
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    repeat (20) @(posedge clk_sys);
    #5 rst = 0;
    paramRdData = 16'h0258;
    wideRdData = 32'h1234_5678;
    foreach (ops[i])
    begin
      d = $random(seed);
      doReq(1, {8'h00, ops[i]}, 8'h1E, d);
      if (ops[i] == OP2_WR32) check(t2WrData, d, "wide write data");
      else if (!isRead(ops[i])) check(t2WrData, {16'h0000, d[15:0]}, "short write data");
      if (!isRead(ops[i])) check({16'h0000, t2WrOpcode, t2WrOperand}, {16'h0000, ops[i], 8'h1E}, "write fields");
    end
    $display("test type2 corners done");
    doReq(0, OP1_VEL_SET, 8'h00, 32'h0000_02D0);
    check({16'h0, velocity}, 32'h0000_02D0, "velocity");
    doReq(0, OP1_MOVE_DIST, 8'h00, 32'h0000_0005);
    check(moveDist, 32'h0000_0005, "move distance");
    doReq(0, OP1_FEED_SENS, 8'h00, {16'h0000, 8'h46, INPUT_TWO});
    check({31'h0, motorRun}, 32'h0, "wrong edge code starts");
    doReq(0, OP1_FEED_SENS, 8'h00, {16'h0000, EDGE_RISING, INPUT_TWO});
    check({31'h0, motorRun}, 32'h1, "feed not started");
    doReq(1, 16'h0083, 8'h1E, 32'h0000_0258); // motion bit in status
    sensorIn2 = 1;
    n = 0;
    while (motorRun === 1'b1 && n < 40)
    begin
      @(posedge clk_sys);
      #5 n++;
    end
    // three sync stages, the arming edge, then five steps
    check(32'(n), 32'h0000_0009, "stop distance after edge");
    sensorIn2 = 0;
    $display("test type1 motion done");
    repeat (30)
    begin
      faultIn = $random(seed);
      paramRdData = $random(seed);
      wideRdData = $random(seed);
      d = $random(seed);
      doReq(1, {8'h00, ops[$unsigned($random(seed)) % 6]}, $random(seed), d);
    end
    $display("test random type2 done");
    test_done();
  end
endmodule
